// ---- inc/timer_defs.svh ----
// Register map, field positions, reset values and timing of the timer block
// Functional notes
// R01 - Pause bit halts counting; module stays powered; clearing resumes normal operation.
// R02 - While paused the count holds; counting resumes from the held value.
// R03 - Clock select: sys/4, sys, high/16, high/64, sub, sub, pin rise, pin fall.
// R04 - On bit rising clears the counter and starts it; only software counter change.
// R05 - On bit falling stops counting; counter keeps its residual value.
// R06 - On bit rising forces the pin to its initial level in output modes.
// R07 - Mode field: 00 compare output, 10 PWM or single pulse, 11 timer; 01 undefined.
// R08 - Software switches the module off before changing the mode field.
// R09 - Compare mode A match: 00 no change, 01 low, 10 high, 11 toggle.
// R10 - PWM mode: 00 inactive, 01 active, 10 PWM, 11 single pulse; unused in timer.
// R11 - Compare mode: requested level equal to initial level gives no visible change.
// R12 - Software changes the output function field only while switched off.
// R13 - Output control bit: initial level in compare mode, active level in PWM modes.
// R14 - Polarity bit inverts the pin signal; ignored in timer mode.
// R15 - Swap bit 0: P sets period, A duty; 1: roles swapped.
// R16 - Clear select high: counter clears on comparator A match.
// R17 - Clear select low: counter clears on P match; overflow clear when P is zero.
// R18 - Clear select has no influence in PWM or single pulse modes.
// R19 - Counter readable, not writable, as low and high byte; both reset zero.
// R20 - Compare A held as read/write byte pair, compare P as one byte.
// R21 - Three lowest bits of control register 0 always read zero.
// R22 - Timer mode: pin state undefined, no output function driven.
// R23 - P compares against counter upper byte; A against all sixteen bits.
// R24 - Clear select low raises A and P flags; high raises only A flag.
// R25 - Compare A zero: counter overflows at ffff, no A flag raised.
// R26 - Counter increments per selected clock edge; pin edges synchronised first.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
// ==========================================================
// Register byte addresses
`define TMR_OFS_CTRL0   8'h00
`define TMR_OFS_CTRL1   8'h04
`define TMR_OFS_CNT_LO  8'h08
`define TMR_OFS_CNT_HI  8'h0c
`define TMR_OFS_CMPA_LO 8'h10
`define TMR_OFS_CMPA_HI 8'h14
`define TMR_OFS_CMPP    8'h18
`define TMR_OFS_STATUS  8'h1c
// ==========================================================
// Field positions and codes
`define TMR_ST_FLAG_A   0
`define TMR_ST_FLAG_P   1
`define TMR_MODE_CMP    2'h0
`define TMR_MODE_PWM    2'h2
`define TMR_MODE_TIMER  2'h3
`define TMR_IO_NONE     2'h0
`define TMR_IO_LOW      2'h1
`define TMR_IO_HIGH     2'h2
`define TMR_IO_TOGGLE   2'h3
`define TMR_RST_BYTE    8'h00
// ==========================================================
// Clock rates in Hz
`define TMR_SYS_HZ      20000000
`define TMR_HIGH_HZ     20000000
`define TMR_SUB_HZ      32768
`endif

// ---- inc/timer_pkg.sv ----
// Types shared by the timer block
package timer_pkg;
	// Control register 0 layout, msb first
	typedef struct packed {
		logic       pause;
		logic [2:0] clk_sel;
		logic       on;
		logic [2:0] rsvd;
	} ctrl0_s;
	// Control register 1 layout, msb first
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] io;
		logic       oc;
		logic       pol;
		logic       dpx;
		logic       cclr;
	} ctrl1_s;
	// Classic Wishbone request and answer
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_s;
endpackage

// ---- rtl/tick_select.sv ----
// Counter clock source selection as one-cycle enable pulses
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module tick_select #(
	parameter int SYS_HZ  = `TMR_SYS_HZ,
	parameter int HIGH_HZ = `TMR_HIGH_HZ,
	parameter int SUB_HZ  = `TMR_SUB_HZ
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Source select and external pin
	input  wire logic [2:0] sel_i,
	input  wire logic       ext_pin_i,
	// Counter enable pulse
	output logic            tick_o
);
	localparam int HDIV = SYS_HZ / HIGH_HZ;
	localparam int SDIV = SYS_HZ / SUB_HZ;
	localparam logic [15:0] HDIV_M1 = 16'(HDIV - 1);
	localparam logic [15:0] SDIV_M1 = 16'(SDIV - 1);
	if (HDIV < 1 || HDIV > 65536 || SDIV < 2 || SDIV > 65536) begin : g_bad
		$error("tick_select: clock ratios out of range");
	end
	logic [15:0] hcnt_q, hcnt_d, scnt_q, scnt_d;
	logic [5:0]  pre_q, pre_d;
	logic [1:0]  div4_q, div4_d;
	logic        sync1_q, sync2_q, sync3_q, tick_q, tick_d, h_en, s_en;
	// Dividers and source mux; pin edges seen only after two flops
	always_comb begin
		h_en   = (hcnt_q == HDIV_M1);
		s_en   = (scnt_q == SDIV_M1);
		hcnt_d = h_en ? 16'h0 : 16'(hcnt_q + 16'h1);
		scnt_d = s_en ? 16'h0 : 16'(scnt_q + 16'h1);
		div4_d = 2'(div4_q + 2'h1);
		pre_d  = h_en ? 6'(pre_q + 6'h1) : pre_q;
		case (sel_i) // see R03
			3'h0: tick_d = (div4_q == 2'h3);
			3'h1: tick_d = 1'b1;
			3'h2: tick_d = h_en && (pre_q[3:0] == 4'hf);
			3'h3: tick_d = h_en && (pre_q == 6'h3f);
			3'h6: tick_d = sync2_q && !sync3_q; // see R26
			3'h7: tick_d = !sync2_q && sync3_q;
			default: tick_d = s_en;
		endcase
	end
	// Registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hcnt_q  <= 16'h0;
			scnt_q  <= 16'h0;
			pre_q   <= 6'h0;
			div4_q  <= 2'h0;
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			tick_q  <= 1'b0;
		end else begin
			hcnt_q  <= hcnt_d;
			scnt_q  <= scnt_d;
			pre_q   <= pre_d;
			div4_q  <= div4_d;
			sync1_q <= ext_pin_i;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			tick_q  <= tick_d;
		end
	end
	assign tick_o = tick_q;
endmodule
`default_nettype wire

// ---- rtl/output_stage.sv ----
// Output pin function, polarity and enable
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module output_stage (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Configuration
	input  wire logic [1:0] mode_i,
	input  wire logic [1:0] io_i,
	input  wire logic       oc_i,
	input  wire logic       pol_i,
	// Internal waveforms
	input  wire logic       cmp_level_i,
	input  wire logic       pwm_act_i,
	input  wire logic       pulse_i,
	// Pin
	output logic            pin_o,
	output logic            pin_oe_o
);
	logic pin_q, pin_d, oe_q, oe_d, lvl;
	// Level per mode, active level taken from the output control bit
	always_comb begin
		lvl  = 1'b0;
		oe_d = 1'b1;
		case (mode_i) // see R07
			`TMR_MODE_CMP: lvl = cmp_level_i;
			`TMR_MODE_PWM: begin
				case (io_i) // see R10
					2'h0: lvl = !oc_i;
					2'h1: lvl = oc_i;
					2'h2: lvl = pwm_act_i ? oc_i : !oc_i; // see R13
					default: lvl = pulse_i ? oc_i : !oc_i;
				endcase
			end
			default: oe_d = 1'b0; // see R22
		endcase
		pin_d = oe_d && (lvl ^ pol_i); // see R14
	end
	// Registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			pin_q <= pin_d;
			oe_q  <= oe_d;
		end
	end
	assign pin_o    = pin_q;
	assign pin_oe_o = oe_q;
endmodule
`default_nettype wire

// ---- rtl/standard_timer_module_control.sv ----
// Sixteen-bit count-up timer with two comparators and a Wishbone slave
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module standard_timer_module_control #(
	parameter int SYS_HZ  = `TMR_SYS_HZ,
	parameter int HIGH_HZ = `TMR_HIGH_HZ,
	parameter int SUB_HZ  = `TMR_SUB_HZ
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Register bus
	input  wire timer_pkg::wb_req_s wb_req_i,
	output timer_pkg::wb_rsp_s     wb_rsp_o,
	// External clock pin, asynchronous
	input  wire logic              external_clock_pin_i,
	// Timer output pin
	output logic                   timer_output_pin_o,
	output logic                   timer_output_pin_oe_o,
	// Sticky match flags
	output logic                   compare_a_match_flag_o,
	output logic                   compare_p_match_flag_o
);
	// ==========================================================
	// Declarations
	timer_pkg::ctrl0_s ctrl0_q, ctrl0_d;
	timer_pkg::ctrl1_s ctrl1_q, ctrl1_d;
	logic [15:0] cmpa_q, cmpa_d;
	logic [7:0]  cmpp_q, cmpp_d;
	logic [15:0] cnt_q, cnt_d;
	logic [16:0] cnt_inc;
	logic [16:0] duty;
	logic        on_prev_q, on_prev_d;
	logic        level_q, level_d;
	logic        pulse_done_q, pulse_done_d;
	logic        flag_a_q, flag_a_d;
	logic        flag_p_q, flag_p_d;
	logic        ack_q, ack_d;
	logic [7:0]  rdat_q, rdat_d;
	logic        req, wr_fire, rd_take;
	logic [7:0]  wadr, wbyte;
	logic        tick, on_rise, run, tick_run;
	logic        pwm_mode, a_hit, p_hit, clr;
	logic        a_evt, p_evt, pwm_act, pulse;

	// ==========================================================
	// Clock source and output pin
	tick_select #(
		.SYS_HZ  (SYS_HZ),
		.HIGH_HZ (HIGH_HZ),
		.SUB_HZ  (SUB_HZ)
	) u_tick (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.sel_i     (ctrl0_q.clk_sel),
		.ext_pin_i (external_clock_pin_i),
		.tick_o    (tick)
	);

	output_stage u_out (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.mode_i      (ctrl1_q.mode),
		.io_i        (ctrl1_q.io),
		.oc_i        (ctrl1_q.oc),
		.pol_i       (ctrl1_q.pol),
		.cmp_level_i (level_q),
		.pwm_act_i   (pwm_act),
		.pulse_i     (pulse),
		.pin_o       (timer_output_pin_o),
		.pin_oe_o    (timer_output_pin_oe_o)
	);

	// ==========================================================
	// Bus decode
	// Writes land on the ack edge, reads are sampled one cycle before
	always_comb begin
		req     = wb_req_i.cyc && wb_req_i.stb;
		wadr    = {wb_req_i.adr[7:2], 2'b00};
		wbyte   = wb_req_i.dat[7:0];
		wr_fire = req && wb_req_i.we && ack_q && wb_req_i.sel[0];
		rd_take = req && !wb_req_i.we && !ack_q;
		ack_d   = req && !ack_q;
	end

	// Read mux; unmapped words answer zero
	always_comb begin
		rdat_d = rdat_q;
		if (rd_take) begin
			case (wadr)
				`TMR_OFS_CTRL0:   rdat_d = {ctrl0_q[7:3], 3'b000}; // see R21
				`TMR_OFS_CTRL1:   rdat_d = ctrl1_q;
				`TMR_OFS_CNT_LO:  rdat_d = cnt_q[7:0]; // see R19
				`TMR_OFS_CNT_HI:  rdat_d = cnt_q[15:8];
				`TMR_OFS_CMPA_LO: rdat_d = cmpa_q[7:0]; // see R20
				`TMR_OFS_CMPA_HI: rdat_d = cmpa_q[15:8];
				`TMR_OFS_CMPP:    rdat_d = cmpp_q;
				`TMR_OFS_STATUS:  rdat_d = {5'h0, level_q, flag_p_q, flag_a_q};
				default:          rdat_d = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Configuration registers
	// Counter bytes have no write path at all
	always_comb begin
		ctrl0_d = ctrl0_q;
		ctrl1_d = ctrl1_q;
		cmpa_d  = cmpa_q;
		cmpp_d  = cmpp_q;
		if (wr_fire) begin
			case (wadr)
				`TMR_OFS_CTRL0:   ctrl0_d = timer_pkg::ctrl0_s'({wbyte[7:3], 3'b000});
				`TMR_OFS_CTRL1:   ctrl1_d = timer_pkg::ctrl1_s'(wbyte);
				`TMR_OFS_CMPA_LO: cmpa_d[7:0] = wbyte;
				`TMR_OFS_CMPA_HI: cmpa_d[15:8] = wbyte;
				`TMR_OFS_CMPP:    cmpp_d = wbyte;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Comparators
	// P sees only the upper byte, so its matches fall on 256-count steps
	always_comb begin
		pwm_mode = (ctrl1_q.mode == `TMR_MODE_PWM);
		on_rise  = ctrl0_q.on && !on_prev_q;
		run      = ctrl0_q.on && !ctrl0_q.pause; // see R01
		tick_run = run && tick && !on_rise;
		cnt_inc  = {1'b0, cnt_q} + 17'h1;
		// A zero never matches, so the count just wraps
		a_hit = tick_run && (cmpa_q != 16'h0) && (cnt_inc[15:0] == cmpa_q); // see R23
		a_hit = a_hit && !cnt_inc[16]; // see R25
		// A zero P value matches only on the wrap to zero
		p_hit = tick_run && (cnt_inc[15:0] == {cmpp_q, 8'h00}); // see R23
		if (pwm_mode) begin
			clr   = ctrl1_q.dpx ? a_hit : p_hit; // see R15
			p_evt = p_hit; // see R18
		end else begin
			clr   = ctrl1_q.cclr ? a_hit : p_hit; // see R16
			p_evt = p_hit && !ctrl1_q.cclr; // see R17
		end
		a_evt = a_hit; // see R24
	end

	// PWM duty; a duty at or above the period gives a steady active level
	always_comb begin
		if (ctrl1_q.dpx)
			duty = (cmpp_q == 8'h0) ? 17'h10000 : {1'b0, cmpp_q, 8'h00};
		else
			duty = {1'b0, cmpa_q};
		pwm_act = ({1'b0, cnt_q} < duty); // see R15
		pulse   = ctrl0_q.on && !pulse_done_q;
	end

	// ==========================================================
	// Counter
	always_comb begin
		on_prev_d = ctrl0_q.on;
		cnt_d     = cnt_q; // see R02, R05
		if (on_rise)
			cnt_d = 16'h0; // see R04
		else if (tick_run)
			cnt_d = clr ? 16'h0 : cnt_inc[15:0]; // see R26
		// Off or paused: the count simply holds
	end

	// ==========================================================
	// Compare output level and single pulse state
	// A requested level equal to the current one is a no-op on the pin
	always_comb begin
		level_d      = level_q;
		pulse_done_d = pulse_done_q;
		if (on_rise) begin
			level_d      = ctrl1_q.oc; // see R06
			pulse_done_d = 1'b0;
		end else if (a_evt) begin
			pulse_done_d = pwm_mode ? 1'b1 : pulse_done_q;
			if (ctrl1_q.mode == `TMR_MODE_CMP) begin
				case (ctrl1_q.io) // see R09
					`TMR_IO_LOW:    level_d = 1'b0; // see R11
					`TMR_IO_HIGH:   level_d = 1'b1;
					`TMR_IO_TOGGLE: level_d = !level_q;
					default:        level_d = level_q;
				endcase
			end
		end
	end

	// ==========================================================
	// Sticky flags, write one to clear; a new match wins over the clear
	always_comb begin
		flag_a_d = flag_a_q;
		flag_p_d = flag_p_q;
		if (wr_fire && wadr == `TMR_OFS_STATUS) begin
			flag_a_d = flag_a_q && !wbyte[`TMR_ST_FLAG_A];
			flag_p_d = flag_p_q && !wbyte[`TMR_ST_FLAG_P];
		end
		flag_a_d = flag_a_d || a_evt;
		flag_p_d = flag_p_d || p_evt;
	end

	// ==========================================================
	// State registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl0_q      <= timer_pkg::ctrl0_s'(`TMR_RST_BYTE);
			ctrl1_q      <= timer_pkg::ctrl1_s'(`TMR_RST_BYTE);
			cmpa_q       <= 16'h0;
			cmpp_q       <= `TMR_RST_BYTE;
			cnt_q        <= 16'h0;
			on_prev_q    <= 1'b0;
			level_q      <= 1'b0;
			pulse_done_q <= 1'b0;
			flag_a_q     <= 1'b0;
			flag_p_q     <= 1'b0;
			ack_q        <= 1'b0;
			rdat_q       <= 8'h00;
		end else begin
			ctrl0_q      <= ctrl0_d;
			ctrl1_q      <= ctrl1_d;
			cmpa_q       <= cmpa_d;
			cmpp_q       <= cmpp_d;
			cnt_q        <= cnt_d;
			on_prev_q    <= on_prev_d;
			level_q      <= level_d;
			pulse_done_q <= pulse_done_d;
			flag_a_q     <= flag_a_d;
			flag_p_q     <= flag_p_d;
			ack_q        <= ack_d;
			rdat_q       <= rdat_d;
		end
	end

	// ==========================================================
	// Outputs
	assign wb_rsp_o.ack           = ack_q;
	assign wb_rsp_o.dat           = {24'h0, rdat_q};
	assign compare_a_match_flag_o = flag_a_q;
	assign compare_p_match_flag_o = flag_p_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_pause_hold: assert property ( // see R01
		(ctrl0_q.pause && !on_rise) |=> $stable(cnt_q))
		else $error("count moved while paused");

	a_resume_step: assert property ( // see R02
		(tick_run && !clr) |=> (cnt_q == 16'($past(cnt_q) + 16'h1)))
		else $error("count did not step from held value");

	a_on_clear: assert property ( // see R04
		on_rise |=> (cnt_q == 16'h0))
		else $error("on rise did not clear count");

	a_off_hold: assert property ( // see R05
		!ctrl0_q.on |=> $stable(cnt_q))
		else $error("count moved while off");

	a_init_level: assert property ( // see R06
		on_rise |=> (level_q == $past(ctrl1_q.oc)))
		else $error("pin level not reset to initial");

	a_match_low: assert property ( // see R09
		(a_evt && !on_rise && ctrl1_q.mode == `TMR_MODE_CMP && ctrl1_q.io == `TMR_IO_LOW)
		|=> !level_q)
		else $error("match did not drive level low");

	a_clear_on_a: assert property ( // see R16
		(a_hit && !pwm_mode && ctrl1_q.cclr) |=> (cnt_q == 16'h0))
		else $error("A match did not clear count");

	a_no_p_flag: assert property ( // see R24
		(!pwm_mode && ctrl1_q.cclr) |-> !p_evt)
		else $error("P flag raised with clear on A");

	a_zero_a: assert property ( // see R25
		(cmpa_q == 16'h0) |-> !a_evt)
		else $error("A flag raised with zero compare");

	a_timer_float: assert property ( // see R22
		(ctrl1_q.mode == `TMR_MODE_TIMER) |=> !timer_output_pin_oe_o)
		else $error("pin driven in timer mode");

	a_ctrl0_rsvd: assert property ( // see R21
		(ack_q && !wb_req_i.we && $past(rd_take) && $past(wadr) == `TMR_OFS_CTRL0)
		|-> (wb_rsp_o.dat[2:0] == 3'h0))
		else $error("reserved control bits not zero");

	a_flag_set: assert property ( // see R24
		a_evt |=> flag_a_q)
		else $error("A flag lost");

	a_p_flag_set: assert property ( // see R24
		p_evt |=> flag_p_q)
		else $error("P flag lost");

	a_p_clear: assert property ( // see R17
		(p_hit && !pwm_mode && !ctrl1_q.cclr) |=> (cnt_q == 16'h0))
		else $error("P match did not clear count");

	a_pwm_clear_fixed: assert property ( // see R18
		(pwm_mode && !ctrl1_q.dpx && ctrl1_q.cclr && a_hit && !p_hit)
		|=> (cnt_q != 16'h0))
		else $error("clear select acted in PWM mode");

	a_swap_period: assert property ( // see R15
		(pwm_mode && ctrl1_q.dpx && a_hit) |=> (cnt_q == 16'h0))
		else $error("A match did not end swapped period");

	a_tick_only: assert property ( // see R26
		(!tick && !on_rise) |=> $stable(cnt_q))
		else $error("count moved without a tick");

	a_match_high: assert property ( // see R09
		(a_evt && ctrl1_q.mode == `TMR_MODE_CMP && ctrl1_q.io == `TMR_IO_HIGH)
		|=> level_q)
		else $error("match did not drive level high");

	a_match_toggle: assert property ( // see R09
		(a_evt && ctrl1_q.mode == `TMR_MODE_CMP && ctrl1_q.io == `TMR_IO_TOGGLE)
		|=> (level_q != $past(level_q)))
		else $error("match did not toggle level");

	a_level_quiet: assert property ( // see R11
		(!on_rise && !(a_evt && ctrl1_q.mode == `TMR_MODE_CMP)) |=> $stable(level_q))
		else $error("level changed without a match");

	a_pin_polarity: assert property ( // see R14
		(ctrl1_q.mode == `TMR_MODE_CMP)
		|=> (timer_output_pin_o == ($past(level_q) ^ $past(ctrl1_q.pol))))
		else $error("pin level or polarity wrong");

	a_pin_forced: assert property ( // see R10
		(pwm_mode && ctrl1_q.io == 2'h1)
		|=> (timer_output_pin_o == ($past(ctrl1_q.oc) ^ $past(ctrl1_q.pol))))
		else $error("pin not at forced active level");

	a_pin_inactive: assert property ( // see R10
		(pwm_mode && ctrl1_q.io == 2'h0)
		|=> (timer_output_pin_o != ($past(ctrl1_q.oc) ^ $past(ctrl1_q.pol))))
		else $error("pin not at forced inactive level");

	a_pwm_active: assert property ( // see R13
		(pwm_mode && ctrl1_q.io == 2'h2 && pwm_act)
		|=> (timer_output_pin_o == ($past(ctrl1_q.oc) ^ $past(ctrl1_q.pol))))
		else $error("PWM active level wrong");

	a_pulse_end: assert property ( // see R10
		(pwm_mode && ctrl1_q.io == 2'h3 && a_evt) |=> !pulse)
		else $error("single pulse did not end");
endmodule
`default_nettype wire

// ---- test/standard_timer_module_control_bench.sv ----
// Self-checking bench for the timer block over its Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module standard_timer_module_control_bench;
	// ==========================================================
	// Signals and instance
	logic                clk;
	logic                rst;
	timer_pkg::wb_req_s  req;
	timer_pkg::wb_rsp_s  rsp;
	logic                ext;
	logic                pin;
	logic                oe;
	logic                fa;
	logic                fp;
	int                  errors;
	int                  n_tests;
	logic [7:0]          d;
	logic [15:0]         c;
	logic [15:0]         c2;
	int                  n;
	// Fast sub clock keeps the divider short
	standard_timer_module_control #(.SUB_HZ(4000000)) u_dut (
		.clk_i                  (clk),
		.rst_i                  (rst),
		.wb_req_i               (req),
		.wb_rsp_o               (rsp),
		.external_clock_pin_i   (ext),
		.timer_output_pin_o     (pin),
		.timer_output_pin_oe_o  (oe),
		.compare_a_match_flag_o (fa),
		.compare_p_match_flag_o (fp)
	);
	// ==========================================================
	// Clock, verdict and watchdog
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic complete_run();
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Whole run is well under this span
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		complete_run();
	end
	// ==========================================================
	// Bus and compare helpers
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One classic cycle; ack is awaited, never assumed
	task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
		output logic [7:0] rd);
		int k;
		k = 0;
		@(posedge clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
		do begin
			@(posedge clk);
			k++;
		end while (rsp.ack !== 1'b1 && k < 20);
		if (k >= 20) begin
			errors++;
			complete_run();
		end
		rd = rsp.dat[7:0];
		req <= '0;
	endtask
	task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
		logic [7:0] x;
		bus(1'b1, adr, wd, x);
	endtask
	task automatic rd_chk(input string name, input logic [7:0] adr, input logic [7:0] exp);
		logic [7:0] x;
		bus(1'b0, adr, 8'h00, x);
		check(name, {8'h00, exp}, {8'h00, x});
	endtask
	task automatic get_cnt(output logic [15:0] v);
		logic [7:0] lo;
		logic [7:0] hi;
		bus(1'b0, `TMR_OFS_CNT_LO, 8'h00, lo);
		bus(1'b0, `TMR_OFS_CNT_HI, 8'h00, hi);
		v = {hi, lo};
	endtask
	// Off, configure, clear flags, then a clean on edge
	task automatic restart(input logic [7:0] c0, input logic [7:0] c1);
		wr(`TMR_OFS_CTRL0, c0 & 8'hf7);
		wr(`TMR_OFS_CTRL1, c1);
		wr(`TMR_OFS_STATUS, 8'h03);
		wr(`TMR_OFS_CTRL0, c0);
	endtask
	task automatic wait_flag(input int lim, input bit p);
		int k;
		k = 0;
		while (((p ? fp : fa) !== 1'b1) && k < lim) begin
			@(posedge clk);
			k++;
		end
	endtask
	task automatic count_high(output int hn);
		hn = 0;
		repeat (512) begin
			@(posedge clk);
			if (pin === 1'b1)
				hn++;
		end
	endtask
	task automatic pulses(input int k);
		repeat (k) begin
			repeat (4) @(posedge clk);
			ext <= 1'b1;
			repeat (4) @(posedge clk);
			ext <= 1'b0;
		end
	endtask
	// ==========================================================
	// Test sequence
	logic [7:0] cm_c1  [5] = '{8'h39, 8'h3d, 8'h19, 8'h29, 8'h09};
	logic       cm_pre [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	logic       cm_post[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	logic [7:0] pw_c1  [4] = '{8'ha9, 8'haa, 8'h98, 8'h88};
	int         pw_exp [4] = '{128, 512, 512, 0};
	int         div    [6] = '{4, 1, 16, 64, 5, 5};
	initial begin
		errors = 0;
		n_tests = 0;
		rst = 1'b1;
		req = '0;
		ext = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// Reset values and access kinds
		rd_chk("ctrl0 reset", `TMR_OFS_CTRL0, 8'h00);
		rd_chk("ctrl1 reset", `TMR_OFS_CTRL1, 8'h00);
		rd_chk("cnt lo reset", `TMR_OFS_CNT_LO, 8'h00);
		rd_chk("cnt hi reset", `TMR_OFS_CNT_HI, 8'h00);
		wr(`TMR_OFS_CTRL0, 8'hf7);
		rd_chk("ctrl0 low bits", `TMR_OFS_CTRL0, 8'hf0);
		wr(`TMR_OFS_CTRL0, 8'h00);
		wr(`TMR_OFS_CNT_LO, 8'hff);
		rd_chk("cnt lo write", `TMR_OFS_CNT_LO, 8'h00);
		wr(`TMR_OFS_CMPA_LO, 8'ha5);
		wr(`TMR_OFS_CMPA_HI, 8'h5a);
		wr(`TMR_OFS_CMPP, 8'h3c);
		rd_chk("cmpa lo", `TMR_OFS_CMPA_LO, 8'ha5);
		rd_chk("cmpa hi", `TMR_OFS_CMPA_HI, 8'h5a);
		rd_chk("cmpp", `TMR_OFS_CMPP, 8'h3c);
		wr(8'h20, 8'h55);
		rd_chk("unmapped", 8'h20, 8'h00);
		// Compare mode: initial level, match action, polarity
		wr(`TMR_OFS_CMPA_LO, 8'h20);
		wr(`TMR_OFS_CMPA_HI, 8'h00);
		for (int k = 0; k < 5; k++) begin
			restart(8'h18, cm_c1[k]);
			repeat (4) @(posedge clk);
			check("initial level", {15'h0, cm_pre[k]}, {15'h0, pin});
			check("pin enable", 16'h1, {15'h0, oe});
			wait_flag(100, 1'b0);
			repeat (3) @(posedge clk);
			check("flag a", 16'h1, {15'h0, fa});
			check("after match", {15'h0, cm_post[k]}, {15'h0, pin});
			check("flag p cclr1", 16'h0, {15'h0, fp});
			get_cnt(c);
			check("cnt below cmpa", 16'h1, {15'h0, c < 16'h0020});
		end
		// Clear on P match, both flags
		wr(`TMR_OFS_CMPP, 8'h01);
		restart(8'h18, 8'h38);
		wait_flag(300, 1'b1);
		check("flag p", 16'h1, {15'h0, fp});
		check("flag a cclr0", 16'h1, {15'h0, fa});
		get_cnt(c);
		check("cnt wraps at p", 16'h0, {8'h00, c[15:8]});
		// Pause, resume, off and restart
		wr(`TMR_OFS_CTRL0, 8'h98);
		get_cnt(c);
		repeat (10) @(posedge clk);
		get_cnt(c2);
		check("paused hold", c, c2);
		wr(`TMR_OFS_CTRL0, 8'h18);
		repeat (7) @(posedge clk);
		get_cnt(c);
		check("resumed", 16'h1, {15'h0, c > c2 && c <= 16'(c2 + 16'h10)});
		wr(`TMR_OFS_CTRL0, 8'h10);
		get_cnt(c);
		repeat (10) @(posedge clk);
		get_cnt(c2);
		check("off hold", c, c2);
		wr(`TMR_OFS_CTRL0, 8'h18);
		get_cnt(c);
		check("on clears", 16'h1, {15'h0, c < 16'h0008});
		// Timer mode and the undefined mode 01 leave the pin undriven
		restart(8'h18, 8'hc0);
		repeat (4) @(posedge clk);
		check("timer oe", 16'h0, {15'h0, oe});
		restart(8'h18, 8'h40);
		repeat (4) @(posedge clk);
		check("mode 01 oe", 16'h0, {15'h0, oe});
		// PWM codes and period/duty swap
		wr(`TMR_OFS_CMPA_LO, 8'h40);
		for (int k = 0; k < 4; k++) begin
			restart(8'h18, pw_c1[k]);
			repeat (8) @(posedge clk);
			count_high(n);
			check("pwm high count", pw_exp[k][15:0], n[15:0]);
		end
		restart(8'h18, 8'hb8);
		count_high(n);
		check("single pulse", 16'h1, {15'h0, n >= 63 && n <= 65});
		// Internal clock sources with compare values at zero
		wr(`TMR_OFS_CMPA_LO, 8'h00);
		wr(`TMR_OFS_CMPP, 8'h00);
		for (int s = 0; s < 6; s++) begin
			restart({1'b0, s[2:0], 4'h8}, 8'hc0);
			repeat (256) @(posedge clk);
			get_cnt(c);
			n = 256 / div[s];
			check("clock rate", 16'h1, {15'h0, int'(c) + 4 >= n && int'(c) <= n + 4});
		end
		// External pin, rising then falling edges
		restart(8'h68, 8'hc0);
		pulses(10);
		repeat (8) @(posedge clk);
		get_cnt(c);
		check("pin rise count", 16'h000a, c);
		restart(8'h78, 8'hc0);
		pulses(10);
		repeat (8) @(posedge clk);
		get_cnt(c);
		check("pin fall count", 16'h000a, c);
		check("no flag a at zero", 16'h0, {15'h0, fa});
		complete_run();
	end
endmodule
`default_nettype wire
